// ==== rtl/hsr_exec.sv ====
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "hsr_defs.svh"
module hsr_exec
  import hsr_pkg::*;
#(
  parameter int SET_W = 2,
  parameter int IMPL_W = 64,
  parameter logic [63:0] IMPL0_VAL = 64'h0000_0000_0000_0000,
  parameter logic [63:0] IMPL1_VAL = 64'h0000_0000_0000_0000
)
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  // Instruction issue
  input wire logic INSTR_VALID_I,
  input wire logic [31:0] INSTR_I,
  input wire logic [63:0] RS_VAL_I,
  input wire logic [63:0] RT_VAL_I,
  // Shadow register write port
  input wire logic SGPR_WE_I,
  input wire logic [SET_W-1:0] SGPR_SET_I,
  input wire logic [4:0] SGPR_IDX_I,
  input wire logic [63:0] SGPR_DATA_I,
  // Writeback and exception
  output logic WB_VALID_O,
  output logic [4:0] WB_IDX_O,
  output logic [63:0] WB_DATA_O,
  output logic RI_EXC_O,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Interrupt
  output logic IRQ_O
);

  if ((IMPL_W != 32) && (IMPL_W != 64))
  begin : g_bad_impl
    $error("IMPL_W must be 32 or 64");
  end
  if ((SET_W < 1) || (SET_W > 4))
  begin : g_bad_set
    $error("SET_W must be 1 to 4");
  end

  localparam int SETS = 2 ** SET_W;

  // Sign extend a 32-bit word
  function automatic hsr_dword_t sext32(input logic [31:0] w);
    sext32 = {{32{w[31]}}, w};
  endfunction : sext32

  // Rotate or shift a word right
  function automatic logic [31:0] turn_right(input logic [31:0] w,
                                             input logic [4:0] s,
                                             input logic rot);
    logic [63:0] dbl;
    dbl = {(rot ? w : 32'h0000_0000), w} >> s;
    turn_right = dbl[31:0];
  endfunction : turn_right

  // Mapped register offsets
  function automatic logic reg_hit(input logic [11:0] a);
    case (a)
      `HSR_REG_CTRL, `HSR_REG_ENA, `HSR_REG_CPUN, `HSR_REG_SYNC,
      `HSR_REG_STAT, `HSR_REG_MASK, `HSR_REG_COUNT: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  // Implementation value width handling
  function automatic hsr_dword_t impl_val(input logic [63:0] v,
                                          input logic ops64);
    if ((IMPL_W == 64) && ops64)
      impl_val = v;
    else
      impl_val = sext32(v[31:0]);
  endfunction : impl_val

  logic [31:0] ctrl;
  logic [31:0] hw_reg_access_enables;
  logic [31:0] cpun_reg;
  logic [31:0] sync_reg;
  logic [`HSR_ST_W-1:0] status;
  logic [`HSR_ST_W-1:0] mask;
  logic [31:0] cycle_count;
  logic [63:0] sgpr [SETS*32];

  logic cp0_usable;
  logic rotate_ext_present_bit;
  logic ops64_en;
  logic [2:0] arch_rev;
  logic [SET_W-1:0] prev_shadow_set_field;
  assign cp0_usable = ctrl[`HSR_CTL_CP0];
  assign rotate_ext_present_bit = ctrl[`HSR_CTL_REXT];
  assign ops64_en = ctrl[`HSR_CTL_64];
  assign arch_rev = ctrl[`HSR_CTL_REV_HI:`HSR_CTL_REV_LO];
  assign prev_shadow_set_field = ctrl[`HSR_CTL_PSS_LO +: SET_W];

  // Instruction fields
  logic [5:0] opc;
  logic [4:0] source_reg_field;
  logic [4:0] target_reg_field;
  logic [4:0] dest_field;
  logic [4:0] shift_amount_field;
  logic [5:0] funct;
  assign opc = INSTR_I[31:26];
  assign source_reg_field = INSTR_I[25:21];
  assign target_reg_field = INSTR_I[20:16];
  assign dest_field = INSTR_I[15:11];
  assign shift_amount_field = INSTR_I[10:6];
  assign funct = INSTR_I[5:0];

  logic read_hw_reg_instr;
  logic read_prev_shadow_instr;
  logic shift_imm;
  logic var_logic_shift_right;
  logic rotate_right_imm;
  logic rotate_right_var;
  assign read_hw_reg_instr = (opc == `HSR_OPC_EXT)
    && (funct == `HSR_FN_READ_HW_REG_INSTR) && (source_reg_field == 5'h00)
    && (shift_amount_field == 5'h00);
  assign read_prev_shadow_instr = (opc == `HSR_OPC_SYSTEM_COPROC_OPCODE)
    && (source_reg_field == `HSR_SYSTEM_COPROC_OPCODE_PGPR)
    && (INSTR_I[10:0] == 11'h000);
  assign shift_imm = (opc == `HSR_OPC_SPECIAL)
    && (funct == `HSR_FN_SRL) && (INSTR_I[25:22] == 4'h0);
  assign var_logic_shift_right = (opc == `HSR_OPC_SPECIAL)
    && (funct == `HSR_FN_VAR_LOGIC_SHIFT_RIGHT) && (INSTR_I[10:7] == 4'h0);
  assign rotate_right_imm = shift_imm && INSTR_I[21];
  assign rotate_right_var = var_logic_shift_right && INSTR_I[6];

  hsr_op_t op;
  logic hw_permit;
  logic next_ri;
  logic [4:0] next_idx;
  hsr_dword_t next_data;
  logic [4:0] amount;
  logic rot;

  always_comb
  begin
    op = HSR_OP_NONE;
    if (read_hw_reg_instr)
      op = HSR_OP_HWR;
    else if (read_prev_shadow_instr)
      op = HSR_OP_PGPR;
    else if (shift_imm || var_logic_shift_right)
      op = HSR_OP_SHIFT;
  end

  assign hw_permit = cp0_usable
    || hw_reg_access_enables[dest_field];

  always_comb
  begin
    next_ri = 1'b0;
    next_idx = dest_field;
    next_data = 64'h0000_0000_0000_0000;
    amount = var_logic_shift_right ? RS_VAL_I[4:0]
                                   : shift_amount_field;
    rot = rotate_right_imm || rotate_right_var;
    case (op)
      HSR_OP_HWR:
      begin
        next_idx = target_reg_field;
        case (dest_field)
          `HSR_HWR_CPUNUM:
            next_data = {{(64-`HSR_CPUN_W){cpun_reg[`HSR_CPUN_W-1]}},
                         cpun_reg[`HSR_CPUN_W-1:0]};
          `HSR_HWR_STEP:
            next_data = {{(64-`HSR_STEP_W){sync_reg[`HSR_STEP_W-1]}},
                         sync_reg[`HSR_STEP_W-1:0]};
          `HSR_HWR_COUNT:
            next_data = sext32(cycle_count);
          `HSR_HWR_RES:
            next_data = {{(64-`HSR_RES_W){
                           sync_reg[`HSR_RES_LO+`HSR_RES_W-1]}},
                         sync_reg[`HSR_RES_LO +: `HSR_RES_W]};
          `HSR_HWR_IMPL0:
            next_data = impl_val(IMPL0_VAL, ops64_en);
          `HSR_HWR_IMPL1:
            next_data = impl_val(IMPL1_VAL, ops64_en);
          default:
            next_ri = 1'b1;
        endcase
        if (!hw_permit)
          next_ri = 1'b1;
        if (arch_rev == `HSR_REV1)
          next_ri = 1'b1;
      end
      HSR_OP_PGPR:
      begin
        next_data = sgpr[{prev_shadow_set_field,
                          target_reg_field}];
        if (arch_rev < `HSR_REV2)
          next_ri = 1'b1;
      end
      HSR_OP_SHIFT:
        // Low word only; upper target bits and missing rotate
        // support are left to software
        next_data = sext32(turn_right(RT_VAL_I[31:0], amount,
                                      rot));
      default:
        next_data = 64'h0000_0000_0000_0000;
    endcase
  end

  logic exec_hit;
  assign exec_hit = INSTR_VALID_I && (op != HSR_OP_NONE);

  // Writeback
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      WB_VALID_O <= 1'b0;
      RI_EXC_O <= 1'b0;
      WB_IDX_O <= 5'h00;
      WB_DATA_O <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      WB_VALID_O <= exec_hit && !next_ri;
      RI_EXC_O <= exec_hit && next_ri;
      if (exec_hit)
      begin
        WB_IDX_O <= next_idx;
        WB_DATA_O <= next_ri ? 64'h0000_0000_0000_0000 : next_data;
      end
    end
  end

  // Free running cycle counter
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cycle_count <= 32'h0000_0000;
    else
      cycle_count <= cycle_count + 32'h0000_0001;
  end

  // Shadow register storage
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SGPR_WE_I)
      sgpr[{SGPR_SET_I, SGPR_IDX_I}] <= SGPR_DATA_I;
  end

  // APB access
  logic apb_wr;
  logic apb_setup;
  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I
    && reg_hit(PADDR_I);

  logic [31:0] rd_mux;
  always_comb
  begin
    case (PADDR_I)
      `HSR_REG_CTRL: rd_mux = ctrl;
      `HSR_REG_ENA: rd_mux = hw_reg_access_enables;
      `HSR_REG_CPUN: rd_mux = cpun_reg;
      `HSR_REG_SYNC: rd_mux = sync_reg;
      `HSR_REG_STAT: rd_mux = {{(32-`HSR_ST_W){1'b0}}, status};
      `HSR_REG_MASK: rd_mux = {{(32-`HSR_ST_W){1'b0}}, mask};
      `HSR_REG_COUNT: rd_mux = cycle_count;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end
    else
    begin
      PREADY_O <= apb_setup;
      PSLVERR_O <= apb_setup && !reg_hit(PADDR_I);
      if (apb_setup && !PWRITE_I)
        PRDATA_O <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      ctrl <= `HSR_CTRL_RST;
      hw_reg_access_enables <= 32'h0000_0000;
      cpun_reg <= 32'h0000_0000;
      sync_reg <= 32'h0000_0000;
      mask <= {`HSR_ST_W{1'b0}};
    end
    else if (apb_wr)
    begin
      case (PADDR_I)
        `HSR_REG_CTRL: ctrl <= PWDATA_I;
        `HSR_REG_ENA: hw_reg_access_enables <= PWDATA_I;
        `HSR_REG_CPUN: cpun_reg <= PWDATA_I;
        `HSR_REG_SYNC: sync_reg <= PWDATA_I;
        `HSR_REG_MASK: mask <= PWDATA_I[`HSR_ST_W-1:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Sticky status, set wins over clear
  logic [`HSR_ST_W-1:0] st_set;
  logic [`HSR_ST_W-1:0] st_clr;
  always_comb
  begin
    st_set = {`HSR_ST_W{1'b0}};
    st_set[`HSR_ST_RI] = exec_hit && next_ri;
    st_set[`HSR_ST_DONE] = exec_hit && !next_ri;
    st_clr = (apb_wr && (PADDR_I == `HSR_REG_STAT))
      ? PWDATA_I[`HSR_ST_W-1:0] : {`HSR_ST_W{1'b0}};
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      status <= {`HSR_ST_W{1'b0}};
    else
      status <= (status & ~st_clr) | st_set;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(status & mask);
  end

endmodule : hsr_exec
`default_nettype wire

// ==== rtl/hsr_defs.svh ====
`ifndef HSR_DEFS_SVH
`define HSR_DEFS_SVH
// Operation
// - Hardware-register read: extension opcode, read-hardware function, source field zero.
// - Permitted read writes sign-extended hardware register to target field register.
// - Read permitted when coprocessor 0 usable or per-register enable bit set.
// - Not permitted or unknown selector raises reserved-instruction, no write.
// - Selector 0 gives CPU number, selector 1 gives cache sync step.
// - Selector 2 gives cycle counter, selector 3 gives counter resolution.
// - Two highest selectors return implementation-dependent values.
// - Implementation value passes whole only if 64 bits and 64-bit ops enabled.
// - First-release configuration treats hardware-register read as reserved instruction.
// - Shadow read: coprocessor-0 opcode, shadow sub-opcode, low 11 bits zero.
// - Shadow read copies previous-set register target into current register destination.
// - Before second release the shadow read raises reserved-instruction.
// - Immediate rotate turns low word right by shift amount, sign-extends.
// - Variable rotate amount is low five bits of source register.
// - Rotate result may be anything if target is not sign-extended word.
// - Rotates undefined below second release when rotate-extension bit clear.
// - Variable rotate: function opcode, variable shift code, bits 10..7 zero.

// Opcode and function encodings
`define HSR_OPC_SPECIAL 6'h00
`define HSR_OPC_EXT 6'h1F
`define HSR_OPC_SYSTEM_COPROC_OPCODE 6'h10
`define HSR_FN_READ_HW_REG_INSTR 6'h3B
`define HSR_FN_SRL 6'h02
`define HSR_FN_VAR_LOGIC_SHIFT_RIGHT 6'h06
`define HSR_SYSTEM_COPROC_OPCODE_PGPR 5'h0A

// Hardware register selectors
`define HSR_HWR_CPUNUM 5'h00
`define HSR_HWR_STEP 5'h01
`define HSR_HWR_COUNT 5'h02
`define HSR_HWR_RES 5'h03
`define HSR_HWR_IMPL0 5'h1E
`define HSR_HWR_IMPL1 5'h1F

// Architecture revisions
`define HSR_REV1 3'h1
`define HSR_REV2 3'h2

// Register offsets
`define HSR_REG_CTRL 12'h000
`define HSR_REG_ENA 12'h004
`define HSR_REG_CPUN 12'h008
`define HSR_REG_SYNC 12'h00C
`define HSR_REG_STAT 12'h010
`define HSR_REG_MASK 12'h014
`define HSR_REG_COUNT 12'h018

// Control fields and reset
`define HSR_CTL_CP0 0
`define HSR_CTL_REXT 1
`define HSR_CTL_64 2
`define HSR_CTL_REV_LO 4
`define HSR_CTL_REV_HI 6
`define HSR_CTL_PSS_LO 8
`define HSR_CTRL_RST 32'h0000_0024
`define HSR_CPUN_W 10
`define HSR_STEP_W 16
`define HSR_RES_LO 16
`define HSR_RES_W 8

// Status bits
`define HSR_ST_RI 0
`define HSR_ST_DONE 1
`define HSR_ST_W 2
`endif

// ==== rtl/hsr_pkg.sv ====
package hsr_pkg;
  typedef enum logic [2:0] {
    HSR_OP_NONE,
    HSR_OP_HWR,
    HSR_OP_PGPR,
    HSR_OP_SHIFT
  } hsr_op_t;
  typedef logic [63:0] hsr_dword_t;
endpackage : hsr_pkg

// ==== testbench/hsr_exec_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module hsr_exec_assertions
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  // Issue
  input wire logic INSTR_VALID_I,
  input wire logic [31:0] INSTR_I,
  input wire logic [63:0] RS_VAL_I,
  input wire logic [63:0] RT_VAL_I,
  // Writeback
  input wire logic WB_VALID_O,
  input wire logic [4:0] WB_IDX_O,
  input wire logic [63:0] WB_DATA_O,
  input wire logic RI_EXC_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [63:0] x_imm;
  logic [63:0] x_var;
  logic [4:0] x_rd;
  logic [4:0] x_rt;
  function automatic logic [63:0] shr(logic [31:0] w, logic [4:0] s,
                                      logic r);
    logic [31:0] q;
    q = (w >> s) | (r ? w << (6'd32 - s) : 32'h0);
    return {{32{q[31]}}, q};
  endfunction : shr
  // Expected results one cycle on
  always_ff @(posedge SYS_CLK_I)
  begin
    x_imm <= shr(RT_VAL_I[31:0], INSTR_I[10:6], INSTR_I[21]);
    x_var <= shr(RT_VAL_I[31:0], RS_VAL_I[4:0], INSTR_I[6]);
    x_rd <= INSTR_I[15:11];
    x_rt <= INSTR_I[20:16];
  end
  sequence s_imm;
    INSTR_VALID_I && INSTR_I[31:22] == 10'h0 && INSTR_I[5:0] == 6'h02;
  endsequence
  sequence s_var;
    INSTR_VALID_I && INSTR_I[31:26] == 6'h0 && INSTR_I[10:7] == 4'h0
      && INSTR_I[5:0] == 6'h06;
  endsequence
  sequence s_hwr;
    INSTR_VALID_I && INSTR_I[31:21] == 11'h3E0 && INSTR_I[10:0] == 11'h03B;
  endsequence
  sequence s_pgp;
    INSTR_VALID_I && INSTR_I[31:21] == 11'h20A && INSTR_I[10:0] == 11'h0;
  endsequence
  chk_wb_cause: assert property (WB_VALID_O |-> $past(INSTR_VALID_I))
    else $error("writeback without an issued instruction");
  chk_ri_alone: assert property (RI_EXC_O |-> !WB_VALID_O)
    else $error("exception together with writeback");
  chk_rot_imm: assert property (s_imm |=> WB_VALID_O
    && WB_DATA_O == x_imm && WB_IDX_O == x_rd)
    else $error("immediate rotate result wrong");
  chk_rot_var: assert property (s_var |=> WB_VALID_O
    && WB_DATA_O == x_var && WB_IDX_O == x_rd)
    else $error("variable rotate result wrong");
  chk_shift_plain: assert property (s_var ##0
    (!INSTR_I[6] && RS_VAL_I[4:0] != 5'h0) |=> !WB_DATA_O[31])
    else $error("plain shift kept high bits");
  chk_hwr_bad: assert property (s_hwr ##0
    INSTR_I[15:11] inside {[5'd4:5'd29]} |=> RI_EXC_O && WB_DATA_O == 64'h0)
    else $error("undefined selector not refused");
  chk_hwr_target: assert property (s_hwr |=> RI_EXC_O
    || WB_VALID_O && WB_IDX_O == x_rt)
    else $error("hardware read wrote wrong register");
  chk_shadow_dest: assert property (s_pgp |=> RI_EXC_O
    || WB_VALID_O && WB_IDX_O == x_rd)
    else $error("shadow read wrote wrong register");
endmodule : hsr_exec_assertions
`default_nettype wire

// ==== testbench/hsr_pipe_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module hsr_pipe_model
(
  // Clock
  input wire logic clk_i,
  // Issue
  output logic iv_o,
  output logic [31:0] ins_o,
  output logic [63:0] rs_o,
  output logic [63:0] rt_o,
  // Shadow write
  output logic we_o,
  output logic [1:0] set_o,
  output logic [4:0] idx_o,
  output logic [63:0] dat_o
);
  initial
  begin
    {iv_o, ins_o, rs_o, rt_o, we_o, set_o, idx_o, dat_o} = '0;
  end
  task automatic issue(input logic [31:0] w, input logic [63:0] s, t);
    iv_o <= 1'b1;
    ins_o <= w;
    rs_o <= s;
    rt_o <= t;
    @(posedge clk_i);
  endtask : issue
  // Released lines carry inverted junk
  task automatic idle();
    iv_o <= 1'b0;
    ins_o <= ~ins_o;
    rs_o <= ~rs_o;
    rt_o <= ~rt_o;
    @(posedge clk_i);
  endtask : idle
  task automatic sg_write(input logic [1:0] s, input logic [4:0] i,
                          input logic [63:0] d);
    we_o <= 1'b1;
    set_o <= s;
    idx_o <= i;
    dat_o <= d;
    @(posedge clk_i);
    we_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask : sg_write
endmodule : hsr_pipe_model
`default_nettype wire

// ==== testbench/tb_hsr_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_hsr_exec;
  import hsr_pkg::*;
  logic clk, rst_b, psel, pen, pwr, iv, we, wbv, ri, rdy, err, irq, e_v;
  logic [11:0] pa;
  logic [31:0] pwd, ins, prd, rd_v, w;
  logic [63:0] rs, rt, sd, wbd, v;
  logic [4:0] si, wbi;
  logic [1:0] ss;
  logic [69:0] e;
  logic [69:0] q[$];
  int n_errors = 0;
  int check_count = 0;
  integer seed = 32'hA04626D2;
  hsr_exec #(.IMPL0_VAL(64'h8123_4567_89AB_CDEF)) hsr_exec_i (
    .SYS_CLK_I(clk), .RST_B_I(rst_b), .INSTR_VALID_I(iv), .INSTR_I(ins),
    .RS_VAL_I(rs), .RT_VAL_I(rt), .SGPR_WE_I(we), .SGPR_SET_I(ss),
    .SGPR_IDX_I(si), .SGPR_DATA_I(sd), .WB_VALID_O(wbv), .WB_IDX_O(wbi),
    .WB_DATA_O(wbd), .RI_EXC_O(ri), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err), .IRQ_O(irq));
  hsr_pipe_model hsr_pipe_model_i (.clk_i(clk), .iv_o(iv), .ins_o(ins),
    .rs_o(rs), .rt_o(rt), .we_o(we), .set_o(ss), .idx_o(si), .dat_o(sd));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [63:0] shr(logic [31:0] a, logic [4:0] s,
                                      logic r);
    logic [31:0] o;
    o = (a >> s) | (r ? a << (6'd32 - s) : 32'h0);
    return {{32{o[31]}}, o};
  endfunction : shr
  function automatic logic [31:0] hw(logic [4:0] r);
    return {11'h3E0, 5'd6, r, 11'h03B};
  endfunction : hw
  task automatic chk(input logic [63:0] s, x);
    check_count++;
    if (s !== x)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd_v = prd;
    e_v = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic run(input logic [31:0] i, input logic [63:0] s, t,
                     input logic x, input logic [4:0] r, input logic [63:0] d);
    q.push_back({x, r, d});
    hsr_pipe_model_i.issue(i, s, t);
  endtask : run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk)
    if (wbv === 1'b1 || ri === 1'b1)
    begin
      e = q.size() ? q.pop_front() : {70{1'bx}};
      chk({63'h0, ri}, {63'h0, e[69]});
      chk(wbd, e[63:0]);
      if (!e[69])
        chk({59'h0, wbi}, {59'h0, e[68:64]});
    end
  initial
  begin
    repeat (4000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    {rst_b, psel, pen, pwr, pa, pwd} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd_v, 32'h24);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(e_v, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      w = $random(seed);
      v = {$random(seed), $random(seed)};
      run({10'h0, k[0], 5'd3, 5'd4, v[4:0], 6'h02}, v, {{32{w[31]}}, w},
          1'b0, 5'd4, shr(w, v[4:0], k[0]));
      run({6'h0, 5'd1, 5'd3, 5'd5, 4'h0, k[0], 6'h06}, v, {{32{w[31]}}, w},
          1'b0, 5'd5, shr(w, v[4:0], k[0]));
    end
    run(hw(5'd0), v, v, 1'b1, 5'd6, 64'h0);
    hsr_pipe_model_i.idle();
    $display("rotate tests done");
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b1, 12'h008, 32'h0000_0200);
    apb(1'b1, 12'h00C, 32'h00AB_8000);
    run(hw(5'd0), v, v, 1'b0, 5'd6, 64'hFFFF_FFFF_FFFF_FE00);
    run(hw(5'd1), v, v, 1'b0, 5'd6, 64'hFFFF_FFFF_FFFF_8000);
    run(hw(5'd3), v, v, 1'b0, 5'd6, 64'hFFFF_FFFF_FFFF_FFAB);
    run(hw(5'd4), v, v, 1'b1, 5'd6, 64'h0);
    run(hw(5'd29), v, v, 1'b1, 5'd6, 64'h0);
    run(hw(5'd30), v, v, 1'b0, 5'd6, 64'h8123_4567_89AB_CDEF);
    run(hw(5'd31), v, v, 1'b0, 5'd6, 64'h0);
    hsr_pipe_model_i.idle();
    apb(1'b1, 12'h000, 32'h20);
    run(hw(5'd30), v, v, 1'b0, 5'd6, 64'hFFFF_FFFF_89AB_CDEF);
    hsr_pipe_model_i.idle();
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h21);
    run(hw(5'd1), v, v, 1'b0, 5'd6, 64'hFFFF_FFFF_FFFF_8000);
    hsr_pipe_model_i.idle();
    apb(1'b1, 12'h000, 32'h11);
    run(hw(5'd1), v, v, 1'b1, 5'd6, 64'h0);
    run({11'h20A, 5'd7, 5'd9, 11'h0}, v, v, 1'b1, 5'd9, 64'h0);
    hsr_pipe_model_i.idle();
    hsr_pipe_model_i.sg_write(2'd2, 5'd7, v);
    apb(1'b1, 12'h000, 32'h224);
    run({11'h20A, 5'd7, 5'd9, 11'h0}, v, v, 1'b0, 5'd9, v);
    hsr_pipe_model_i.idle();
    $display("hardware and shadow tests done");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd_v[1:0], 2'b11);
    apb(1'b1, 12'h014, 32'h1);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h010, 32'h3);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("interrupt tests done");
    chk(q.size(), 0);
    complete_run();
  end
endmodule : tb_hsr_exec
bind hsr_exec hsr_exec_assertions hsr_exec_assertions_i (
  .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .INSTR_VALID_I(INSTR_VALID_I),
  .INSTR_I(INSTR_I), .RS_VAL_I(RS_VAL_I), .RT_VAL_I(RT_VAL_I),
  .WB_VALID_O(WB_VALID_O), .WB_IDX_O(WB_IDX_O), .WB_DATA_O(WB_DATA_O),
  .RI_EXC_O(RI_EXC_O));
`default_nettype wire
